// ---- timer_output_pin_remap.sv ----
/*
  Timer output pin remap: one APB register of selectors that steers each
  timer output channel of the variant onto its default or alternate port pin,
  except timer1 output B2, which is parked while on its default pin and timer0 output1 holds port C5.
  Assumes timer outputs are synchronous to pclk; port logic merges the
  drive and enable vectors with its other shared functions.
*/
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module timer_output_pin_remap #(
  parameter logic [1:0] VARIANT = 2'h2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire pin_remap_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer channels
  input wire pin_remap_pkg::timer_outs_t timer_outs,
  // Pin drive
  output var pin_remap_pkg::pin_bus_t pin_out,
  output var pin_remap_pkg::pin_bus_t pin_oe
);
  import pin_remap_pkg::*;

  localparam logic [7:0] IMPL_MASK = (VARIANT == VARIANT_SMALL) ? MASK_SMALL :
                                     (VARIANT == VARIANT_MID) ? MASK_MID : MASK_LARGE;

  logic [SEL_WIDTH-1:0] pin_select;
  logic [SEL_WIDTH-1:0] next_pin_select;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  pin_bus_t next_out;
  pin_bus_t next_oe;
  logic setup;
  logic commit;
  logic hit;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, answers in the first access cycle

  assign setup = apb_req.psel && !apb_req.penable;
  // Commit on the acknowledged access edge, never in setup
  assign commit = apb_req.psel && apb_req.penable && pready;
  assign hit = (apb_req.paddr == SEL_REG_OFFSET);

  always_comb begin
    next_pin_select = pin_select;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (setup) begin
      next_pready = 1'b1;
      next_pslverr = !hit;
      next_prdata = 32'h0000_0000;
      if (hit && !apb_req.pwrite) begin
        next_prdata = {24'h00_0000, pin_select};
      end
    end
    // Unimplemented bits read as zero and ignore writes
    if (commit && hit && apb_req.pwrite) begin
      next_pin_select = apb_req.pwdata[SEL_WIDTH-1:0] & IMPL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_select <= SEL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pin_select <= next_pin_select;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin routing; registered so outputs come straight from flops,
  // at the cost of one cycle of latency on the timer waveforms

  always_comb begin
    next_out = '0;
    next_oe = '0;
    // Timer0 output0
    if (pin_select[T0_OUT0_BIT]) begin
      next_out.port_d[0] = timer_outs.timer0_output0;
      next_oe.port_d[0] = 1'b1;
    end else begin
      next_out.port_a[0] = timer_outs.timer0_output0;
      next_oe.port_a[0] = 1'b1;
    end
    // Timer0 output1: default pin depends on the variant
    if (pin_select[T0_OUT1_BIT]) begin
      next_out.port_d[1] = timer_outs.timer0_output1;
      next_oe.port_d[1] = 1'b1;
    end else if (VARIANT == VARIANT_SMALL) begin
      next_out.port_a[7] = timer_outs.timer0_output1;
      next_oe.port_a[7] = 1'b1;
    end else begin
      next_out.port_c[5] = timer_outs.timer0_output1;
      next_oe.port_c[5] = 1'b1;
    end
    // Timer1 output A
    if (pin_select[T1_A_BIT]) begin
      next_out.port_d[2] = timer_outs.timer1_output_a;
      next_oe.port_d[2] = 1'b1;
    end else begin
      next_out.port_a[1] = timer_outs.timer1_output_a;
      next_oe.port_a[1] = 1'b1;
    end
    if (VARIANT != VARIANT_SMALL) begin
      // Port C5 is shared with timer0 output1 default on mid and large parts
      if (pin_select[T1_B_OUT2_BIT]) begin
        next_out.port_d[5] = timer_outs.timer1_output_b2;
        next_oe.port_d[5] = 1'b1;
      end else if (!next_oe.port_c[5]) begin
        next_out.port_c[5] = timer_outs.timer1_output_b2;
        next_oe.port_c[5] = 1'b1;
      end
      if (pin_select[T2_OUT0_BIT]) begin
        next_out.port_d[6] = timer_outs.timer2_output0;
        next_oe.port_d[6] = 1'b1;
      end else begin
        next_out.port_c[3] = timer_outs.timer2_output0;
        next_oe.port_c[3] = 1'b1;
      end
      if (pin_select[T2_OUT1_BIT]) begin
        next_out.port_d[7] = timer_outs.timer2_output1;
        next_oe.port_d[7] = 1'b1;
      end else begin
        next_out.port_c[4] = timer_outs.timer2_output1;
        next_oe.port_c[4] = 1'b1;
      end
    end
    if (VARIANT == VARIANT_LARGE) begin
      if (pin_select[T3_OUT0_BIT]) begin
        next_out.port_f[0] = timer_outs.timer3_output0;
        next_oe.port_f[0] = 1'b1;
      end else begin
        next_out.port_g[3] = timer_outs.timer3_output0;
        next_oe.port_g[3] = 1'b1;
      end
      if (pin_select[T3_OUT1_BIT]) begin
        next_out.port_f[1] = timer_outs.timer3_output1;
        next_oe.port_f[1] = 1'b1;
      end else begin
        next_out.port_g[0] = timer_outs.timer3_output1;
        next_oe.port_g[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_select & ~IMPL_MASK) == 8'h00)
    else $error("unimplemented select bit set");

  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    commit && hit && apb_req.pwrite |=> pin_select == ($past(apb_req.pwdata[7:0]) & IMPL_MASK))
    else $error("register write did not land");

  a_no_stray_write: assert property (@(posedge pclk) disable iff (!presetn)
    !(commit && hit && apb_req.pwrite) |=> $stable(pin_select))
    else $error("select changed without a write");

  a_ready_follows: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready && (pslverr == !$past(hit)))
    else $error("no answer after setup");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  a_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    setup && hit && !apb_req.pwrite |=> prdata == {24'h00_0000, $past(pin_select)})
    else $error("read data wrong");

  a_miss_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !hit |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_t0o0_route: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_oe.port_d[0] == $past(pin_select[T0_OUT0_BIT])
             && pin_oe.port_a[0] == !$past(pin_select[T0_OUT0_BIT])
             && pin_out.port_d[0] == ($past(pin_select[T0_OUT0_BIT])
                                      & $past(timer_outs.timer0_output0)))
    else $error("timer0 output0 routed wrong");

  a_t0o1_alt: assert property (@(posedge pclk) disable iff (!presetn)
    pin_select[T0_OUT1_BIT] |=> pin_oe.port_d[1] && !pin_oe.port_a[7])
    else $error("timer0 output1 alternate pin wrong");

  a_t1a_route: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_oe.port_d[2] != pin_oe.port_a[1])
    else $error("timer1 output A driven on both or neither pin");

  a_t1a_level: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_out.port_a[1] == (!$past(pin_select[T1_A_BIT]) & $past(timer_outs.timer1_output_a)))
    else $error("timer1 output A level wrong");

  a_t0o1_dflt: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT != VARIANT_SMALL) && !pin_select[T0_OUT1_BIT] |=> pin_oe.port_c[5]
      && pin_out.port_c[5] == $past(timer_outs.timer0_output1))
    else $error("timer0 output1 default pin wrong");

  a_c5_shared: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT != VARIANT_SMALL) && !pin_select[T0_OUT1_BIT] && !pin_select[T1_B_OUT2_BIT]
      |=> !pin_oe.port_d[5])
    else $error("timer1 output B2 drives while parked");

  a_t1b2_dflt: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT != VARIANT_SMALL) && pin_select[T0_OUT1_BIT] && !pin_select[T1_B_OUT2_BIT]
      |=> pin_oe.port_c[5] && pin_out.port_c[5] == $past(timer_outs.timer1_output_b2))
    else $error("timer1 output B2 default pin wrong");

  a_t1b2_route: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT != VARIANT_SMALL) && pin_select[T1_B_OUT2_BIT] |=> pin_oe.port_d[5]
      && pin_out.port_d[5] == $past(timer_outs.timer1_output_b2))
    else $error("timer1 output B2 alternate wrong");

  a_t2o0_route: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT != VARIANT_SMALL) |=> pin_oe.port_d[6] == $past(pin_select[T2_OUT0_BIT])
      && pin_oe.port_c[3] == !$past(pin_select[T2_OUT0_BIT]))
    else $error("timer2 output0 routed wrong");

  a_t2o0_level: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT != VARIANT_SMALL) |=> pin_out.port_d[6]
      == ($past(pin_select[T2_OUT0_BIT]) & $past(timer_outs.timer2_output0)))
    else $error("timer2 output0 level wrong");

  a_t2o1_route: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT != VARIANT_SMALL) |=> pin_oe.port_d[7] == $past(pin_select[T2_OUT1_BIT])
      && pin_oe.port_c[4] == !$past(pin_select[T2_OUT1_BIT]))
    else $error("timer2 output1 routed wrong");

  a_t3o0_route: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT == VARIANT_LARGE) |=> pin_oe.port_f[0] == $past(pin_select[T3_OUT0_BIT])
      && pin_oe.port_g[3] == !$past(pin_select[T3_OUT0_BIT]))
    else $error("timer3 output0 routed wrong");

  a_t3o1_route: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT == VARIANT_LARGE) |=> pin_oe.port_f[1] == $past(pin_select[T3_OUT1_BIT])
      && pin_oe.port_g[0] == !$past(pin_select[T3_OUT1_BIT]))
    else $error("timer3 output1 routed wrong");

  a_t3o1_level: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT == VARIANT_LARGE) |=> pin_out.port_f[1]
      == ($past(pin_select[T3_OUT1_BIT]) & $past(timer_outs.timer3_output1)))
    else $error("timer3 output1 level wrong");

  a_t3o0_level: assert property (@(posedge pclk) disable iff (!presetn)
    (VARIANT == VARIANT_LARGE) |=> pin_out.port_g[3]
      == (!$past(pin_select[T3_OUT0_BIT]) & $past(timer_outs.timer3_output0)))
    else $error("timer3 output0 level wrong");

  a_unclaimed_off: assert property (@(posedge pclk) disable iff (!presetn)
    pin_oe.port_f[7:2] == 6'h00 && pin_oe.port_g[2:1] == 2'h0 && pin_oe.port_g[7:4] == 4'h0)
    else $error("unclaimed pin enabled");

  a_idle_low_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((pin_out.port_c & ~pin_oe.port_c) == 8'h00)
             && ((pin_out.port_f & ~pin_oe.port_f) == 8'h00)
             && ((pin_out.port_g & ~pin_oe.port_g) == 8'h00))
    else $error("undriven pin carries a level");

  a_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((pin_out.port_a & ~pin_oe.port_a) == 8'h00)
             && ((pin_out.port_d & ~pin_oe.port_d) == 8'h00))
    else $error("undriven pin carries a level");
endmodule
`default_nettype wire

// ---- pin_remap_pkg.sv ----
/*
  Package for the timer output pin remap block: register offset, field
  positions, reset value, variant encoding and the carrier structs.
  Assumes a 32-bit APB3 master and a single 125 MHz clock domain.
*/
`default_nettype none
package pin_remap_pkg;
  localparam logic [11:0] SEL_REG_OFFSET = 12'h000;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam int SEL_WIDTH = 8;
  // Implemented-bit masks per variant
  localparam logic [7:0] MASK_SMALL = 8'h07;
  localparam logic [7:0] MASK_MID = 8'h3f;
  localparam logic [7:0] MASK_LARGE = 8'hff;
  localparam logic [1:0] VARIANT_SMALL = 2'h0;
  localparam logic [1:0] VARIANT_MID = 2'h1;
  localparam logic [1:0] VARIANT_LARGE = 2'h2;
  // Field positions within the select register
  localparam int T0_OUT0_BIT = 0;
  localparam int T0_OUT1_BIT = 1;
  localparam int T1_A_BIT = 2;
  localparam int T1_B_OUT2_BIT = 3;
  localparam int T2_OUT0_BIT = 4;
  localparam int T2_OUT1_BIT = 5;
  localparam int T3_OUT0_BIT = 6;
  localparam int T3_OUT1_BIT = 7;

  typedef struct packed {
    logic timer3_output1;
    logic timer3_output0;
    logic timer2_output1;
    logic timer2_output0;
    logic timer1_output_b2;
    logic timer1_output_a;
    logic timer0_output1;
    logic timer0_output0;
  } timer_outs_t;

  // Per-pin level and enable for each port bit the block can claim
  typedef struct packed {
    logic [7:0] port_a;
    logic [7:0] port_c;
    logic [7:0] port_d;
    logic [7:0] port_f;
    logic [7:0] port_g;
  } pin_bus_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage
`default_nettype wire

// ---- tb.sv ----
/*
  Self-checking bench for the timer output pin remap block, large variant.
  Assumes the design answers APB within 20 access cycles and registers pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pin_remap_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t req = '0;
  timer_outs_t touts = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pin_bus_t pin_out;
  pin_bus_t pin_oe;
  int seed = 87;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] sel_exp = 8'h00;
  // Flat pin index: a=32+n, c=24+n, d=16+n, f=8+n, g=n
  int dflt_idx[8] = '{32, 29, 33, 29, 27, 28, 3, 0};
  int alt_idx[8] = '{16, 17, 18, 21, 22, 23, 8, 9};

  timer_output_pin_remap #(.VARIANT(VARIANT_LARGE)) i_timer_output_pin_remap (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_outs(touts), .pin_out(pin_out), .pin_oe(pin_oe));

  always #4 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [79:0] exp_pins(input logic [7:0] s, input logic [7:0] t);
    logic [39:0] o;
    logic [39:0] e;
    int k;
    o = '0;
    e = '0;
    for (int b = 0; b < 8; b++) begin
      k = s[b] ? alt_idx[b] : dflt_idx[b];
      // Shared C5: timer0 output1 wins while both clear
      if (!(b == 3 && !s[3] && !s[1])) begin
        e[k] = 1'b1;
        o[k] = t[b];
      end
    end
    return {o, e};
  endfunction

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Holds the request until pready is seen; no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    req.paddr <= a;
    req.pwrite <= wr;
    req.pwdata <= d;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk(1, 0);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk(err, exp_err);
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk({err, rd}, {exp_err, exp});
  endtask

  // Outputs lag the timer inputs by one registered stage
  task automatic run_pins(input int n);
    logic [7:0] old;
    repeat (n) begin
      @(posedge pclk);
      old = touts;
      touts <= $random(seed);
      @(negedge pclk);
      chk({pin_out, pin_oe}, exp_pins(sel_exp, old));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reg_rd(12'h000, 32'h0, 1'b0);
    run_pins(4);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i < 10) ? 8'h01 << (i - 2) : $random(seed);
      reg_wr(12'h000, {$random(seed), v}, 1'b0);
      sel_exp = v;
      reg_rd(12'h000, {24'h0, v}, 1'b0);
      run_pins(6);
    end
    $display("test select patterns done");
    reg_wr(12'h004, 32'h0000_005a, 1'b1);
    reg_wr({$random(seed)} % 12'hfff + 12'h001, 32'h0000_00c3, 1'b1);
    reg_rd(12'h004, 32'h0, 1'b1);
    reg_rd(12'h000, {24'h0, sel_exp}, 1'b0);
    $display("test unmapped done");
    reg_wr(12'h000, 32'h0000_00a5, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    chk({pin_out, pin_oe}, 80'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    sel_exp = 8'h00;
    @(posedge pclk);
    reg_rd(12'h000, 32'h0, 1'b0);
    run_pins(6);
    $display("test mid reset done");
    test_done();
  end

  // Whole run is a few hundred cycles
  initial begin
    #(20000 * 8);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
